// ---- include/err_node_pkg.sv ----
// Package with register map, field positions and error type encodings for the error record node.
package err_node_pkg;

    // =====================================================================
    // Register byte offsets.
    // =====================================================================
    localparam logic [11:0] feature_off = 12'h000;
    localparam logic [11:0] control_off = 12'h008;
    localparam logic [11:0] status_off = 12'h010;
    localparam logic [11:0] addr_off = 12'h018;
    localparam logic [11:0] misc0_off = 12'h020;
    localparam logic [11:0] misc1_off = 12'h024;
    localparam logic [11:0] misc2_off = 12'h028;
    localparam logic [11:0] misc3_off = 12'h02c;
    localparam logic [11:0] count_off = 12'h030;

    // =====================================================================
    // Status register fields.
    // =====================================================================
    localparam int st_valid = 31;
    localparam int st_uncorrected = 29;
    localparam int st_overflow = 27;
    localparam int st_deferred = 23;
    localparam int st_ce_lo = 24;
    localparam int st_subtype_lo = 20;

    // =====================================================================
    // Control register fields.
    // =====================================================================
    localparam int ctl_enable = 0;
    localparam int ctl_inband = 1;
    localparam int ctl_fault_ue = 3;
    localparam int ctl_recover = 2;
    localparam int ctl_fault_ce = 8;
    localparam int ctl_recover_de = 10;
    localparam logic [31:0] ctl_reset = 32'h0000_0000;
    localparam logic [31:0] ctl_mask = 32'h0000_050f;

    // =====================================================================
    // Feature register contents.
    // =====================================================================
    localparam logic [31:0] feature_value = 32'h0000_6aa5;

    // =====================================================================
    // Uncorrected sub-type encodings and priority classes.
    // =====================================================================
    localparam logic [1:0] latent_or_restartable = 2'h2;
    localparam logic [1:0] signaled_or_recoverable = 2'h3;
    localparam logic [1:0] unrecoverable_kind = 2'h1;
    localparam logic [1:0] uncontainable_kind = 2'h0;

    typedef enum logic [2:0] {
        sev_none,
        sev_ce,
        sev_de,
        sev_ue_low,
        sev_ue_mid,
        sev_ue_unrec,
        sev_ue_uc
    } severity_type;

endpackage : err_node_pkg

// ---- src/error_record_node.sv ----
// Error record node: classifies detected errors, records syndrome and reports them.
`timescale 1ns/1ps
// Function
// RQ1: Corrected only if detected and corrected.
// RQ2: Deferred when not corrected, not propagated.
// RQ3: Possibly propagated deferred becomes uncorrected.
// RQ4: Uncontainable if propagated, else unrecoverable.
// RQ5: Latent when detected, unconsumed, not deferred.
// RQ6: Signaled when possibly consumed, not deferred.
// RQ7: Unrecoverable then means node cannot continue.
// RQ8: Restartable when halted without needing data.
// RQ9: Recoverable when halted operation needs data.
// RQ10: Unrecoverable then means cannot resume.
// RQ11: Record has status and address registers.
// RQ12: Version one needs two misc registers.
// RQ13: Later version provides four misc registers.
// RQ14: Same layout for both access views.
// RQ15: Records survive the error recovery reset; here recovery_rstn clears them, and only rstn leaves them.
// RQ16: Control disables reporting and logging.
// RQ17: Separate fault enables for corrected, others.
// RQ18: Counter wrap is overflow, raises interrupt.
// RQ19: In-band abort only for uncorrected errors.
// RQ20: Recovery interrupt uncorrected, deferred if enabled.
// RQ21: Recovery interrupt even when syndrome discarded.
// RQ22: One feature and one control register.
// RQ23: Status keeps highest priority type encoding.
// RQ24: Update flags and count corrected errors.
// RQ25: Interrupts are levels until status cleared.
// RQ26: Critical interrupt to system controller.
module error_record_node
    import err_node_pkg::*;
#(
    parameter int cnt_width = 8,
    parameter int addr_width = 32
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic recovery_rstn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic err_valid,
    input wire logic err_corrected,
    input wire logic err_deferred,
    input wire logic err_propagated,
    input wire logic err_consumed,
    input wire logic err_halted,
    input wire logic err_needs_data,
    input wire logic err_fatal,
    input wire logic err_critical,
    input wire logic [addr_width-1:0] err_addr,
    input wire logic [31:0] err_syndrome,
    output logic inband_abort,
    output logic fault_irq,
    output logic recovery_irq,
    output logic critical_irq
);
    import err_node_pkg::*;

    // =====================================================================
    // Classification of the incoming error.
    // =====================================================================
    severity_type new_sev;
    logic [1:0] new_subtype;
    always_comb
    begin
        new_subtype = uncontainable_kind;
        if (err_corrected)
        begin
            new_sev = sev_ce; // [RQ1]
        end
        else if (err_deferred && !err_propagated)
        begin
            new_sev = sev_de; // [RQ2]
        end
        else if (err_propagated)
        begin
            new_sev = sev_ue_uc; // [RQ3] [RQ4]
            new_subtype = uncontainable_kind;
        end
        else if (err_halted && !err_fatal)
        begin
            new_sev = err_needs_data ? sev_ue_mid : sev_ue_low; // [RQ8] [RQ9]
            new_subtype = err_needs_data ? signaled_or_recoverable : latent_or_restartable;
        end
        else if (!err_halted && !err_fatal)
        begin
            new_sev = err_consumed ? sev_ue_mid : sev_ue_low; // [RQ5] [RQ6]
            new_subtype = err_consumed ? signaled_or_recoverable : latent_or_restartable;
        end
        else
        begin
            new_sev = sev_ue_unrec; // [RQ4] [RQ7] [RQ10]
            new_subtype = unrecoverable_kind;
        end
    end

    // =====================================================================
    // Bus decode.
    // =====================================================================
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] ctl_r;
    logic [31:0] st_w1c;
    logic ctl_wr;
    logic st_wr;
    logic cnt_wr;
    logic misc_wr;
    logic [1:0] misc_idx;
    assign ctl_wr = wr_pend_r && wr_addr_r == control_off;
    assign st_wr = wr_pend_r && wr_addr_r == status_off;
    assign cnt_wr = wr_pend_r && wr_addr_r == count_off;
    assign misc_wr = wr_pend_r && wr_addr_r[11:4] == misc0_off[11:4] && wr_addr_r[5];
    assign misc_idx = wr_addr_r[3:2];
    assign st_w1c = st_wr ? hwdata : 32'h0000_0000;

    logic take;
    assign take = hsel && hready && htrans[1];

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end
        else
        begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= {haddr[11:2], 2'h0};
        end
    end

    // =====================================================================
    // Control register, one for the node.
    // =====================================================================
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctl_r <= ctl_reset;
        end
        else if (ctl_wr)
        begin
            ctl_r <= hwdata & ctl_mask; // [RQ22]
        end
    end

    logic logging_on;
    assign logging_on = ctl_r[ctl_enable]; // [RQ16]
    logic ev;
    assign ev = err_valid && logging_on;

    // =====================================================================
    // Error record; reset only by recovery_rstn power-on, not by rstn.
    // =====================================================================
    logic valid_r;
    logic [1:0] ce_r;
    logic de_r;
    logic ue_r;
    logic of_r;
    logic [1:0] subtype_r;
    severity_type sev_r;
    logic [addr_width-1:0] addr_r;
    logic [31:0] misc_r [4];
    logic [cnt_width-1:0] cnt_r;
    logic overwrite;
    logic cnt_wrap;
    assign overwrite = ev && (new_sev > sev_r || !valid_r || st_w1c[st_valid]);
    assign cnt_wrap = ev && new_sev == sev_ce && (&cnt_r); // [RQ18]

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            valid_r <= 1'b0;
        end
        else
        begin
            valid_r <= ev || (valid_r && !st_w1c[st_valid]); // [RQ15] [RQ24]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            ce_r <= 2'h0;
        end
        else
        begin
            ce_r <= (ev && new_sev == sev_ce) ? 2'h2 : (st_w1c[st_ce_lo+1] ? 2'h0 : ce_r); // [RQ24]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            de_r <= 1'b0;
        end
        else
        begin
            de_r <= (ev && new_sev == sev_de) || (de_r && !st_w1c[st_deferred]); // [RQ24]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            ue_r <= 1'b0;
        end
        else
        begin
            ue_r <= (ev && new_sev >= sev_ue_low) || (ue_r && !st_w1c[st_uncorrected]); // [RQ24]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            of_r <= 1'b0;
        end
        else
        begin
            of_r <= cnt_wrap || (ev && valid_r && !overwrite && new_sev != sev_ce)
                || (of_r && !st_w1c[st_overflow]); // [RQ18]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            sev_r <= sev_none;
            subtype_r <= 2'h0;
        end
        else if (overwrite)
        begin
            sev_r <= new_sev; // [RQ23]
            subtype_r <= new_subtype;
        end
        else if (st_w1c[st_valid])
        begin
            sev_r <= sev_none;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            addr_r <= '0;
        end
        else if (overwrite)
        begin
            addr_r <= err_addr; // [RQ11]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                misc_r[i] <= 32'h0000_0000;
            end
        end
        else if (overwrite)
        begin
            misc_r[0] <= err_syndrome; // [RQ12] [RQ13]
        end
        else if (misc_wr)
        begin
            misc_r[misc_idx] <= hwdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!recovery_rstn)
        begin
            cnt_r <= '0;
        end
        else if (ev && new_sev == sev_ce)
        begin
            cnt_r <= cnt_r + 1'b1; // [RQ24]
        end
        else if (cnt_wr)
        begin
            cnt_r <= hwdata[cnt_width-1:0]; // [RQ18]
        end
    end

    // =====================================================================
    // Reporting outputs, interrupt levels held while the status stays set; inband_abort pulses for one cycle.
    // =====================================================================
    logic ue_any;
    logic fault_nxt;
    logic recover_nxt;
    assign ue_any = ue_r;
    assign fault_nxt = (ctl_r[ctl_fault_ce] && (ce_r != 2'h0 || of_r))
        || (ctl_r[ctl_fault_ue] && (de_r || ue_r)); // [RQ17] [RQ25]
    assign recover_nxt = ctl_r[ctl_recover] && (ue_any || (ctl_r[ctl_recover_de] && de_r)); // [RQ20] [RQ21]

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            inband_abort <= 1'b0;
            fault_irq <= 1'b0;
            recovery_irq <= 1'b0;
        end
        else
        begin
            inband_abort <= ev && ctl_r[ctl_inband] && new_sev >= sev_ue_low && err_consumed; // [RQ19]
            fault_irq <= fault_nxt; // [RQ25]
            recovery_irq <= recover_nxt; // [RQ25]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            critical_irq <= 1'b0;
        end
        else
        begin
            critical_irq <= (ev && err_critical) || (critical_irq && !st_w1c[st_valid]); // [RQ26]
        end
    end

    // =====================================================================
    // Read path, zero-wait AHB-Lite slave.
    // =====================================================================
    logic [31:0] rd_nxt;
    always_comb
    begin
        case ({haddr[11:2], 2'h0})
            feature_off: rd_nxt = feature_value; // [RQ22]
            control_off: rd_nxt = ctl_r;
            status_off: rd_nxt = {valid_r, 1'b0, ue_r, 1'b0, of_r, 1'b0, ce_r, de_r,
                1'b0, subtype_r, 20'h00000}; // [RQ14]
            addr_off: rd_nxt = 32'(addr_r);
            misc0_off: rd_nxt = misc_r[0];
            misc1_off: rd_nxt = misc_r[1];
            misc2_off: rd_nxt = misc_r[2];
            misc3_off: rd_nxt = misc_r[3];
            count_off: rd_nxt = 32'(cnt_r);
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite)
            begin
                hrdata <= rd_nxt;
            end
        end
    end

endmodule // error_record_node

// ---- bench/err_source.sv ----
// Error source model driving the detection side of the node.
`timescale 1ns/1ps
module err_source
(
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] kind,
    input wire logic [31:0] where,
    input wire logic [31:0] syn,
    output logic err_valid,
    output logic [7:0] qual,
    output logic [31:0] err_addr,
    output logic [31:0] err_syndrome
);
    // ====
    // Qualifiers only mean something with err_valid, so idle cycles carry noise.
    always_ff @(posedge clk)
    begin
        err_valid <= go;
        qual <= go ? kind : 8'($urandom);
        err_addr <= go ? where : ~where;
        err_syndrome <= go ? syn : ~syn;
    end
endmodule // err_source

// ---- bench/node_chk.sv ----
// Checker of the error record node port behaviour.
`timescale 1ns/1ps
module node_chk
    import err_node_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic err_valid,
    input wire logic err_corrected,
    input wire logic err_deferred,
    input wire logic err_propagated,
    input wire logic inband_abort,
    input wire logic fault_irq,
    input wire logic recovery_irq,
    input wire logic critical_irq
);
    // ====
    // Properties.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire rd = hsel && hready && htrans[1] && !hwrite;
    ready_high_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    feature_read_a: assert property (rd && haddr == feature_off |=> hrdata == feature_value)
        else $error("feature read wrong");
    rdata_hold_a: assert property ($past(rstn) && !$past(rd) |-> $stable(hrdata))
        else $error("hrdata moved without read");
    irq_reset_a: assert property ($rose(rstn) |-> !fault_irq && !recovery_irq && !critical_irq)
        else $error("irq high after reset");
    abort_cause_a: assert property (inband_abort |-> $past(err_valid) && !$past(err_corrected)
        && !($past(err_deferred) && !$past(err_propagated)))
        else $error("abort without uncorrected error");
    crit_cause_a: assert property ($rose(critical_irq) |-> $past(err_valid))
        else $error("critical irq without error");
    recov_no_ce_a: assert property ($rose(recovery_irq) |-> !($past(err_valid, 2) && $past(err_corrected, 2)))
        else $error("recovery irq from corrected");
    cover property (inband_abort);
    cover property ($rose(critical_irq));
    cover property ($rose(recovery_irq));
endmodule // node_chk

bind error_record_node node_chk chk (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .err_valid, .err_corrected, .err_deferred, .err_propagated, .inband_abort,
    .fault_irq, .recovery_irq, .critical_irq);

// ---- bench/tb_error_record_node.sv ----
// Testbench comparing the error record node with a behavioural model.
`timescale 1ns/1ps
module tb_error_record_node;
    import err_node_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic recovery_rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic go = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] kind = 8'h00;
    logic [31:0] where = 32'h0;
    logic [31:0] syn = 32'h0;
    logic [31:0] rd, s, hrdata, err_addr, err_syndrome;
    logic [7:0] q;
    logic err_valid, hreadyout, hresp, inband_abort, fault_irq, recovery_irq, critical_irq;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int abort_count = 0;
    int a0 = 0;
    int tbl[$] = '{8'h01, 8'h02, 8'h06, 8'h0c, 8'h38, 8'h18, 8'h08, 8'h00, 8'h48, 8'h80};
    initial forever #10 clk = ~clk;
    err_source src (.clk(clk), .go(go), .kind(kind), .where(where), .syn(syn), .err_valid(err_valid),
        .qual(q), .err_addr(err_addr), .err_syndrome(err_syndrome));
    error_record_node DUT (.clk, .rstn, .recovery_rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .err_valid, .err_corrected(q[0]),
        .err_deferred(q[1]), .err_propagated(q[2]), .err_consumed(q[3]), .err_halted(q[4]),
        .err_needs_data(q[5]), .err_fatal(q[6]), .err_critical(q[7]), .err_addr, .err_syndrome,
        .inband_abort, .fault_irq, .recovery_irq, .critical_irq);
    // ====
    // Model and tasks.
    function automatic logic [31:0] cls(input int k);
        int sub;
        if (k & 1)
            return 32'h8200_0000;
        if ((k & 6) == 2)
            return 32'h8080_0000;
        sub = (k & 4) ? 0 : (k & 64) ? 1 : ((((k & 16) ? k >> 5 : k >> 3) & 1) ? 3 : 2);
        return 32'ha000_0000 | (sub << 20);
    endfunction
    task print_verdict();
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (inband_abort === 1'b1)
            abort_count <= abort_count + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task reg_is(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask
    task send(input logic [7:0] k);
        kind <= k;
        where <= $urandom;
        syn <= $urandom;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // ====
    // Main sequence.
    initial
    begin
        s = $urandom(6851);
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        recovery_rstn <= 1'b1;
        @(posedge clk);
        reg_is(feature_off, feature_value);
        reg_is(control_off, ctl_reset);
        reg_is(12'h100, 32'h0);
        bus(1'b1, control_off, 32'hffff_ffff);
        reg_is(control_off, ctl_mask);
        for (int j = 0; j < 3; j++)
        begin
            s = $urandom;
            bus(1'b1, misc1_off + 12'(4 * j), s);
            reg_is(misc1_off + 12'(4 * j), s);
        end
        $display("registers done");
        foreach (tbl[n])
        begin
            bus(1'b1, status_off, 32'hffff_ffff);
            repeat (2) @(posedge clk);
            cmp({29'h0, fault_irq, recovery_irq, critical_irq}, 32'h0);
            a0 = abort_count;
            send(8'(tbl[n]));
            reg_is(status_off, cls(tbl[n]));
            reg_is(misc0_off, syn);
            reg_is(addr_off, where);
            cmp({29'h0, fault_irq, recovery_irq, critical_irq}, {29'h0, 1'b1, ~kind[0], kind[7]});
            cmp(32'(abort_count - a0), 32'((cls(tbl[n]) >> 29) & (tbl[n] >> 3) & 1));
        end
        $display("classes done");
        send(8'h0c);
        s = syn;
        reg_is(status_off, 32'ha000_0000);
        send(8'h00);
        reg_is(status_off, 32'ha800_0000);
        reg_is(misc0_off, s);
        cmp({31'h0, recovery_irq}, 32'h1);
        $display("priority done");
        bus(1'b1, status_off, 32'hffff_ffff);
        bus(1'b1, count_off, 32'hff);
        reg_is(count_off, 32'hff);
        send(8'h01);
        reg_is(count_off, 32'h0);
        reg_is(status_off, 32'h8a00_0000);
        $display("counter done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        reg_is(status_off, 32'h8a00_0000);
        send(8'h08);
        reg_is(status_off, 32'h8a00_0000);
        recovery_rstn <= 1'b0;
        @(posedge clk);
        recovery_rstn <= 1'b1;
        @(posedge clk);
        reg_is(status_off, 32'h0);
        $display("resets done");
        print_verdict();
    end
endmodule // tb_error_record_node
